/* File: quad_equalizer_boost_config.sv */
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module quad_equalizer_boost_config #(
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // serial configuration pins
    input wire logic serial_clk,
    input wire logic serial_config_in,
    input wire logic serial_load_enable,
    input wire logic boost_mode_serial,
    output logic serial_config_out,
    // level select pins, [2] is pin a
    input wire logic [2:0] eq1_level_pins,
    input wire logic [2:0] eq2_level_pins,
    input wire logic [2:0] eq3_level_pins,
    input wire logic [2:0] eq4_level_pins,
    // power and idle pins
    input wire logic [3:0] impedance_select,
    input wire logic idle_detect_threshold,
    input wire logic [3:0] idle_power_below,
    // channel controls
    output logic [19:0] boost_level,
    output logic [3:0] channel_power_down,
    output logic [3:0] channel_input_hiz,
    output logic [3:0] channel_mute,
    output logic [3:0] limiter_enable
);

    localparam int unsigned NCH = quad_eq_pkg::CHAN_COUNT;
    localparam int unsigned LW = quad_eq_pkg::LEVEL_W;

    // ----------------------------------------
    // input synchronisers and serial clock edge
    // ----------------------------------------
    logic [quad_eq_pkg::SY_W-1:0] sync1_reg;
    logic [quad_eq_pkg::SY_W-1:0] sync2_reg;
    logic sclk_prev_reg;
    logic [quad_eq_pkg::SY_W-1:0] pins_raw;
    logic sclk_rise;
    logic mode_s;
    logic thr_s;

    assign pins_raw = {eq4_level_pins, eq3_level_pins, eq2_level_pins, eq1_level_pins,
        idle_power_below, impedance_select, idle_detect_threshold, boost_mode_serial,
        serial_load_enable, serial_config_in, serial_clk};

    // data and clock pass equal depth, so data is aligned with the detected edge
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sclk_prev_reg <= 1'h0;
        end
        else
        begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            sclk_prev_reg <= sync2_reg[quad_eq_pkg::SY_SCLK];
        end
    end

    assign sclk_rise = sync2_reg[quad_eq_pkg::SY_SCLK] && !sclk_prev_reg;
    assign mode_s = sync2_reg[quad_eq_pkg::SY_MODE];
    assign thr_s = sync2_reg[quad_eq_pkg::SY_THR];

    // ----------------------------------------
    // boost register chain
    // ----------------------------------------
    chain_if #(.LEN(quad_eq_pkg::CHAIN_LEN)) chain_bus ();

    assign chain_bus.clear = !mode_s;
    assign chain_bus.shift_pulse = sclk_rise && mode_s
        && sync2_reg[quad_eq_pkg::SY_EN];
    assign chain_bus.data_in = sync2_reg[quad_eq_pkg::SY_DIN];

    boost_chain #(.LEN(quad_eq_pkg::CHAIN_LEN)) u_chain (
        .clk(clk),
        .rstn(rstn),
        .chain_port(chain_bus.store)
    );

    // ----------------------------------------
    // per-channel control
    // ----------------------------------------
    logic [3:0] ctrl_reg;
    wire [NCH*LW-1:0] boost_next;
    wire [NCH-1:0] pd_next;
    wire [NCH-1:0] mute_next;
    wire [NCH-1:0] lim_next;

    for (genvar k = 0; k < NCH; k++)
    begin : g_chan
        logic [2:0] code;
        logic [LW-1:0] pin_level;
        logic [LW-1:0] ser_level;
        assign code = sync2_reg[quad_eq_pkg::SY_PINS + 3*k +: 3];
        assign pin_level = quad_eq_pkg::PIN_LEVEL_TABLE[code];
        assign ser_level = chain_bus.chain[quad_eq_pkg::FIELD_BASE + LW*k +: LW];
        assign boost_next[LW*k +: LW] = mode_s ? ser_level : pin_level;
        assign pd_next[k] = !sync2_reg[quad_eq_pkg::SY_IMP + k] || ctrl_reg[k];
        // a grounded threshold pin turns idle muting off entirely
        assign mute_next[k] = thr_s && sync2_reg[quad_eq_pkg::SY_IDLE + k];
        assign lim_next[k] = !mute_next[k];
    end

    logic serial_out_reg;
    logic [NCH*LW-1:0] boost_reg;
    logic [NCH-1:0] pd_reg;
    logic [NCH-1:0] mute_reg;
    logic [NCH-1:0] lim_reg;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            serial_out_reg <= 1'h0;
            boost_reg <= '0;
            pd_reg <= '0;
            mute_reg <= '0;
            lim_reg <= '0;
        end
        else
        begin
            serial_out_reg <= chain_bus.chain[quad_eq_pkg::CHAIN_LEN-1];
            boost_reg <= boost_next;
            pd_reg <= pd_next;
            mute_reg <= mute_next;
            lim_reg <= lim_next;
        end
    end

    assign serial_config_out = serial_out_reg;
    assign boost_level = boost_reg;
    assign channel_power_down = pd_reg;
    assign channel_input_hiz = pd_reg;
    assign channel_mute = mute_reg;
    assign limiter_enable = lim_reg;

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic [3:0] ctrl_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    assign wa = 8'(awaddr_reg);
    assign ra = 8'(s_axi_araddr);

    always_comb
    begin
        rd_word = '0;
        rd_resp = quad_eq_pkg::RESP_OKAY;
        if (ra == quad_eq_pkg::ADDR_CTRL)
            rd_word = 32'(ctrl_reg);
        else if (ra == quad_eq_pkg::ADDR_STATUS)
        begin
            rd_word[quad_eq_pkg::ST_IMP +: 4] = sync2_reg[quad_eq_pkg::SY_IMP +: 4];
            rd_word[quad_eq_pkg::ST_MODE] = mode_s;
            rd_word[quad_eq_pkg::ST_EN] = sync2_reg[quad_eq_pkg::SY_EN];
            rd_word[quad_eq_pkg::ST_THR] = thr_s;
        end
        else if (ra == quad_eq_pkg::ADDR_BOOST)
            rd_word = 32'(boost_reg);
        else if (ra == quad_eq_pkg::ADDR_CHAIN)
            rd_word = 32'(chain_bus.chain);
        else if (ra == quad_eq_pkg::ADDR_IDLE)
        begin
            rd_word[quad_eq_pkg::IDLE_MUTE +: 4] = mute_reg;
            rd_word[quad_eq_pkg::IDLE_PD +: 4] = pd_reg;
            rd_word[quad_eq_pkg::IDLE_RAW +: 4] = sync2_reg[quad_eq_pkg::SY_IDLE +: 4];
        end
        else
            rd_resp = quad_eq_pkg::RESP_DECERR;
    end

    always_comb
    begin
        awready_next = awready_reg;
        wready_next = wready_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        ctrl_next = ctrl_reg;
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        // a low ready means that half of the write is held
        if (s_axi_awvalid && awready_reg)
        begin
            awready_next = 1'h0;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            wready_next = 1'h0;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'h0;
        // write commits only once both halves are in and no response is pending
        if (!awready_reg && !wready_reg && !bvalid_reg)
        begin
            awready_next = 1'h1;
            wready_next = 1'h1;
            bvalid_next = 1'h1;
            bresp_next = quad_eq_pkg::RESP_OKAY;
            if (wa == quad_eq_pkg::ADDR_CTRL)
            begin
                if (wstrb_reg[0])
                    ctrl_next = wdata_reg[3:0];
            end
            else if (wa != quad_eq_pkg::ADDR_STATUS && wa != quad_eq_pkg::ADDR_BOOST
                && wa != quad_eq_pkg::ADDR_CHAIN && wa != quad_eq_pkg::ADDR_IDLE)
                bresp_next = quad_eq_pkg::RESP_DECERR;
        end
        if (s_axi_arvalid && arready_reg)
        begin
            arready_next = 1'h0;
            rvalid_next = 1'h1;
            rdata_next = rd_word;
            rresp_next = rd_resp;
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'h0;
            arready_next = 1'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            awready_reg <= quad_eq_pkg::READY_RESET;
            wready_reg <= quad_eq_pkg::READY_RESET;
            bvalid_reg <= 1'h0;
            bresp_reg <= quad_eq_pkg::RESP_OKAY;
            ctrl_reg <= quad_eq_pkg::CTRL_RESET;
            arready_reg <= quad_eq_pkg::READY_RESET;
            rvalid_reg <= 1'h0;
            rdata_reg <= '0;
            rresp_reg <= quad_eq_pkg::RESP_OKAY;
        end
        else
        begin
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            ctrl_reg <= ctrl_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule

`default_nettype wire

/* File: quad_eq_pkg.sv */
package quad_eq_pkg;

    // ----------------------------------------
    // channel and chain layout
    // ----------------------------------------
    localparam int unsigned CHAN_COUNT = 4;
    localparam int unsigned LEVEL_W = 5;
    localparam int unsigned LEVEL_COUNT = 32;
    localparam int unsigned PIN_CODE_W = 3;
    localparam int unsigned PIN_LEVEL_COUNT = 18;
    localparam int unsigned CHAIN_LEN = 21;
    // extra stage sits at bit 0, channel k field at [5k+5:5k+1]
    localparam int unsigned FIELD_BASE = 1;
    localparam logic [CHAIN_LEN-1:0] CHAIN_RESET = 21'h000000;

    // level reached by each 3-bit pin code, all drawn from the pin subset
    localparam logic [7:0][LEVEL_W-1:0] PIN_LEVEL_TABLE = {
        5'h1f, 5'h1c, 5'h18, 5'h14, 5'h10, 5'h0c, 5'h08, 5'h00
    };

    // ----------------------------------------
    // synchroniser vector layout
    // ----------------------------------------
    localparam int unsigned SY_SCLK = 0;
    localparam int unsigned SY_DIN = 1;
    localparam int unsigned SY_EN = 2;
    localparam int unsigned SY_MODE = 3;
    localparam int unsigned SY_THR = 4;
    localparam int unsigned SY_IMP = 5;
    localparam int unsigned SY_IDLE = 9;
    localparam int unsigned SY_PINS = 13;
    localparam int unsigned SY_W = 25;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_BOOST = 8'h08;
    localparam logic [7:0] ADDR_CHAIN = 8'h0c;
    localparam logic [7:0] ADDR_IDLE = 8'h10;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam int unsigned ST_IMP = 0;
    localparam int unsigned ST_MODE = 4;
    localparam int unsigned ST_EN = 5;
    localparam int unsigned ST_THR = 6;
    localparam int unsigned IDLE_MUTE = 0;
    localparam int unsigned IDLE_PD = 4;
    localparam int unsigned IDLE_RAW = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic READY_RESET = 1'h1;

endpackage

/* File: chain_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface chain_if #(
    parameter int unsigned LEN = 21
);
    logic shift_pulse;
    logic clear;
    logic data_in;
    logic [LEN-1:0] chain;

    modport ctrl (output shift_pulse, output clear, output data_in, input chain);
    modport store (input shift_pulse, input clear, input data_in, output chain);
endinterface

`default_nettype wire

/* File: boost_chain.sv */
`timescale 1ns/1ps
`default_nettype none

module boost_chain #(
    parameter int unsigned LEN = 21
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // shift control and contents
    chain_if.store chain_port
);

    logic [LEN-1:0] chain_reg;
    logic [LEN-1:0] chain_next;

    always_comb
    begin
        chain_next = chain_reg;
        if (chain_port.clear)
        begin
            chain_next = '0;
        end
        else if (chain_port.shift_pulse)
        begin
            chain_next = {chain_reg[LEN-2:0], chain_port.data_in};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            chain_reg <= '0;
        end
        else
        begin
            chain_reg <= chain_next;
        end
    end

    assign chain_port.chain = chain_reg;

endmodule

`default_nettype wire

/* File: quad_eq_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// channel and link checks
// ----------------------------------------
module quad_eq_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pins
    input wire logic serial_clk,
    input wire logic serial_load_enable,
    input wire logic boost_mode_serial,
    input wire logic [2:0] eq1_level_pins,
    input wire logic [3:0] impedance_select,
    input wire logic idle_detect_threshold,
    input wire logic [3:0] idle_power_below,
    // outputs
    input wire logic serial_config_out,
    input wire logic [19:0] boost_level,
    input wire logic [3:0] channel_power_down,
    input wire logic [3:0] channel_input_hiz,
    input wire logic [3:0] channel_mute,
    input wire logic [3:0] limiter_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // windows leave room for two sync flops and the output register
    hiz_pd_a: assert property (!impedance_select[0] [*4] |-> channel_input_hiz[0])
        else $error("channel inputs not high impedance");
    imp_pd_a: assert property (!impedance_select[1] [*4] |-> channel_power_down[1])
        else $error("channel not powered down");
    idle_mute_a: assert property ((idle_detect_threshold && idle_power_below[2]) [*4]
        |-> channel_mute[2]) else $error("idle channel not muted");
    thr_gnd_a: assert property (!idle_detect_threshold [*4] |-> channel_mute == 4'h0)
        else $error("mute with threshold grounded");
    limiter_inv_a: assert property ($past(rstn) && $past(rstn, 2)
        |-> limiter_enable == ~channel_mute) else $error("limiter not inverse of mute");
    pin_level_a: assert property ((!boost_mode_serial && $stable(eq1_level_pins)) [*6]
        |-> boost_level[4:0] == quad_eq_pkg::PIN_LEVEL_TABLE[eq1_level_pins])
        else $error("pin level mismatch");
    mode_clr_a: assert property (!boost_mode_serial [*5] |-> !serial_config_out)
        else $error("chain not cleared");
    en_hold_a: assert property ((boost_mode_serial && !serial_load_enable) [*8]
        |-> $stable(serial_config_out) && $stable(boost_level)) else $error("chain moved");
    clk_hold_a: assert property ((boost_mode_serial && $stable(serial_clk)) [*8]
        |-> $stable(serial_config_out)) else $error("out moved without clock");
    cover property (channel_mute[2]);
    cover property (channel_power_down[1]);
    cover property ($changed(serial_config_out));
endmodule

bind quad_equalizer_boost_config quad_eq_asserts quad_eq_asserts_inst (
    .clk(clk), .rstn(rstn), .serial_clk(serial_clk),
    .serial_load_enable(serial_load_enable), .boost_mode_serial(boost_mode_serial),
    .eq1_level_pins(eq1_level_pins), .impedance_select(impedance_select),
    .idle_detect_threshold(idle_detect_threshold), .idle_power_below(idle_power_below),
    .serial_config_out(serial_config_out), .boost_level(boost_level),
    .channel_power_down(channel_power_down), .channel_input_hiz(channel_input_hiz),
    .channel_mute(channel_mute), .limiter_enable(limiter_enable)
);

`default_nettype wire

/* File: serial_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// module controller on the serial link
// ----------------------------------------
module serial_ctl_model (
    // serial link toward the device
    output logic serial_clk,
    output logic serial_config_in,
    output logic serial_load_enable,
    output logic boost_mode_serial
);
    // clock rests low between frames, data sits at its pull-down level
    initial
    begin
        serial_clk = 1'b0;
        serial_config_in = 1'b0;
        serial_load_enable = 1'b0;
        boost_mode_serial = 1'b0;
    end

    // the offset keeps link edges clear of the system clock edges
    task set_mode(input logic mode, input logic en);
        #1.3;
        boost_mode_serial = mode;
        serial_load_enable = en;
    endtask

    // data settles a quarter period before the rise and holds well past it
    task send_bit(input logic b);
        serial_config_in = b;
        #16;
        serial_clk = 1'b1;
        #32;
        serial_clk = 1'b0;
        #16;
        serial_config_in = 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: quad_equalizer_boost_config_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module quad_equalizer_boost_config_bench;
    // ----------------------------------------
    // signals and reference chain
    // ----------------------------------------
    logic clk, rstn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, sco, thr;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, got;
    logic [3:0] ws, imp, idle, pd, hiz, mute, lim;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] pins [4];
    logic [19:0] boost;
    logic [20:0] m;
    wire logic sclk, sdin, sen, smode;
    int bad_count, checks;

    quad_equalizer_boost_config quad_equalizer_boost_config_inst (
        .clk(clk), .rstn(rstn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .serial_clk(sclk), .serial_config_in(sdin), .serial_load_enable(sen),
        .boost_mode_serial(smode), .serial_config_out(sco),
        .eq1_level_pins(pins[0]), .eq2_level_pins(pins[1]), .eq3_level_pins(pins[2]),
        .eq4_level_pins(pins[3]), .impedance_select(imp), .idle_detect_threshold(thr),
        .idle_power_below(idle), .boost_level(boost), .channel_power_down(pd),
        .channel_input_hiz(hiz), .channel_mute(mute), .limiter_enable(lim)
    );
    serial_ctl_model serial_ctl_model_inst (
        .serial_clk(sclk), .serial_config_in(sdin), .serial_load_enable(sen),
        .boost_mode_serial(smode)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // whole run needs about 16 us
    initial
    begin
        #100us;
        bad_count++;
        conclude;
    end

    task conclude;
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task chk_bus(input logic [1:0] r, input logic [31:0] d,
        input logic [1:0] er, input logic [31:0] ed);
        chk({30'h0, r}, {30'h0, er});
        chk(d, ed);
    endtask

    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        br <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr)
                wv <= 1'b0;
            if (bv)
            begin
                r = bresp;
                br <= 1'b0;
                break;
            end
        end
    endtask

    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rr <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arv && arr)
                arv <= 1'b0;
            if (rv)
            begin
                d = rd;
                r = rresp;
                rr <= 1'b0;
                break;
            end
        end
    endtask

    task pins_check;
        for (int k = 0; k < 4; k++)
            chk(32'(boost[5*k+:5]), 32'(quad_eq_pkg::PIN_LEVEL_TABLE[pins[k]]));
    endtask

    task boost_check;
        for (int k = 0; k < 4; k++)
            chk(32'(boost[5*k+:5]), 32'(m[5*k+1+:5]));
    endtask

    task shift_bit(input logic b);
        serial_ctl_model_inst.send_bit(b);
        m = {m[19:0], b};
        chk(32'(sco), 32'(m[20]));
        boost_check;
    endtask

    initial
    begin
        rstn = 1'b0;
        {awv, wv, br, arv, rr} = 5'h00;
        {awa, ara, wd} = 48'h0;
        ws = 4'hf;
        imp = 4'hf;
        idle = 4'h0;
        thr = 1'b1;
        pins = '{default: 3'h0};
        bad_count = 0;
        checks = 0;
        m = 21'h0;
        got = $urandom(32'h1cfe);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        axi_rd(quad_eq_pkg::ADDR_CHAIN, got, resp);
        chk_bus(resp, got, quad_eq_pkg::RESP_OKAY, 32'h0);
        axi_rd(8'h40, got, resp);
        chk_bus(resp, got, quad_eq_pkg::RESP_DECERR, 32'h0);
        axi_wr(8'h40, 32'h1, resp);
        chk_bus(resp, 32'h0, quad_eq_pkg::RESP_DECERR, 32'h0);
        axi_wr(quad_eq_pkg::ADDR_CTRL, 32'h2, resp);
        chk_bus(resp, 32'h0, quad_eq_pkg::RESP_OKAY, 32'h0);
        // no strobe on the low byte: the control word must not move
        ws <= 4'he;
        axi_wr(quad_eq_pkg::ADDR_CTRL, 32'hf, resp);
        ws <= 4'hf;
        axi_wr(quad_eq_pkg::ADDR_STATUS, 32'hf, resp);
        chk_bus(resp, 32'h0, quad_eq_pkg::RESP_OKAY, 32'h0);
        repeat (4) @(posedge clk);
        chk(32'(pd), 32'h2);
        axi_rd(quad_eq_pkg::ADDR_CTRL, got, resp);
        chk_bus(resp, got, quad_eq_pkg::RESP_OKAY, 32'h2);
        axi_wr(quad_eq_pkg::ADDR_CTRL, 32'h0, resp);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk);
            imp <= 4'(i);
            idle <= ~4'(i);
            thr <= (i > 7);
            repeat (6) @(posedge clk);
            // integer forms: a signed 4-bit cast would sign-extend
            chk(32'(pd), 32'(15 - i));
            chk(32'(hiz), 32'(15 - i));
            chk(32'(mute), (i > 7) ? 32'(15 - i) : 32'h0);
            chk(32'(lim), (i > 7) ? 32'(i) : 32'hf);
            axi_rd(quad_eq_pkg::ADDR_IDLE, got, resp);
            chk_bus(resp, got, quad_eq_pkg::RESP_OKAY,
                (32'(15 - i) << quad_eq_pkg::IDLE_RAW)
                | (32'(15 - i) << quad_eq_pkg::IDLE_PD)
                | ((i > 7) ? 32'(15 - i) << quad_eq_pkg::IDLE_MUTE : 32'h0));
            axi_rd(quad_eq_pkg::ADDR_STATUS, got, resp);
            chk_bus(resp, got, quad_eq_pkg::RESP_OKAY,
                (32'(i) << quad_eq_pkg::ST_IMP) | (32'(i > 7) << quad_eq_pkg::ST_THR));
        end
        for (int c = 0; c < 8; c++)
        begin
            @(posedge clk);
            for (int k = 0; k < 4; k++)
                pins[k] <= 3'(c + k);
            repeat (6) @(posedge clk);
            pins_check;
        end
        // pins stay random under serial mode, the chain must win
        @(posedge clk);
        for (int k = 0; k < 4; k++)
            pins[k] <= 3'($urandom);
        serial_ctl_model_inst.set_mode(1'b1, 1'b1);
        #24;
        for (int lv = 0; lv < 32; lv++)
            for (int j = 5; j >= 0; j--)
                shift_bit(j > 0 ? 1'(lv >> (j - 1)) : 1'($urandom));
        for (int n = 0; n < 21; n++)
            shift_bit(1'($urandom));
        serial_ctl_model_inst.set_mode(1'b1, 1'b0);
        #24;
        @(posedge clk);
        pins[0] <= ~pins[0];
        for (int n = 0; n < 5; n++)
            serial_ctl_model_inst.send_bit(1'($urandom));
        chk(32'(sco), 32'(m[20]));
        boost_check;
        axi_rd(quad_eq_pkg::ADDR_CHAIN, got, resp);
        chk_bus(resp, got, quad_eq_pkg::RESP_OKAY, 32'(m));
        axi_rd(quad_eq_pkg::ADDR_BOOST, got, resp);
        chk_bus(resp, got, quad_eq_pkg::RESP_OKAY, 32'(m[20:1]));
        serial_ctl_model_inst.set_mode(1'b0, 1'b1);
        #24;
        m = 21'h0;
        chk(32'(sco), 32'h0);
        pins_check;
        axi_rd(quad_eq_pkg::ADDR_CHAIN, got, resp);
        chk_bus(resp, got, quad_eq_pkg::RESP_OKAY, 32'h0);
        conclude;
    end
endmodule

`default_nettype wire
